// File: stc_acq.sv
// Scope acquisition time base: divider, trigger select, pre/post counting,
// sample latch into a ring memory, interpolation count and cal output mux.
// Assumes all inputs synchronous to clk; clk stands for the 250 MHz reference
// time base, with clk_en low freezing everything.
//
// Overview of operation
// - Ring memory 8000 deep, tracked by clock count
// - Memory stores on both edges of its clock
// - Eight-bit samples latched before memory write
// - Pre-trigger count reached raises arm
// - Trigger received starts post-trigger countdown
// - Countdown zero stops clocks, signals complete
// - Four trigger sources selectable
// - Bus trigger bypasses level comparison
// - Level compare runs continuously, feeds logic
// - Pulse from trigger to next sample edge
// - Counter runs until interpolator reports done
// - Final interpolation count is stored
// - Sample rates divided from reference by program
// - Cal mux picks one of four by mode
`timescale 1ns/1ns
`include "stc_params.svh"

module stc_acq
   import stc_pkg::*;
#(
   parameter int RING_DEPTH = `STC_RING_DEPTH,
   parameter int SW         = `STC_SAMPLE_BITS
) (
   // Clock and control
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      clk_en,
   input  wire logic                      start,
   input  wire stc_cfg_t                  cfg,
   // Converter and trigger inputs
   input  wire logic [SW-1:0]             adc_ch1,
   input  wire logic [SW-1:0]             adc_ch2,
   input  wire logic                      intermodule_trigger_input,
   input  wire logic                      external_trigger_input,
   input  wire logic                      self_cal_signal,
   input  wire logic                      interp_done,
   // Readback of stored samples
   input  wire logic [12:0]               rd_index,
   output stc_sample_t                    rd_data,
   // Status and outputs
   output logic                           trigger_arm,
   output logic                           acq_complete,
   output logic                           ring_clock,
   output logic                           interp_pulse,
   output logic [`STC_INTERP_BITS-1:0]    interp_count,
   output logic [12:0]                    ring_position,
   output logic                           rear_calibration_mux
);

   // ----------------------------------------------------------------
   // Sample clock divider
   // ----------------------------------------------------------------
   logic [`STC_DIV_BITS-1:0] div_cnt;
   logic                     sample_tick;
   logic                     clocks_run;
   stc_state_t               state;

   assign clocks_run  = (state == ST_PRE) || (state == ST_ARMED) || (state == ST_POST);
   assign sample_tick = clocks_run && (div_cnt == '0);

   always_ff @(posedge clk) begin
      if (rst || !clocks_run) begin
         div_cnt <= '0;
      end else if (clk_en) begin
         if (div_cnt >= cfg.sample_div)
            div_cnt <= '0;
         else
            div_cnt <= div_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Trigger source selection and level compare
   // ----------------------------------------------------------------
   logic ch1_above;
   logic ch2_above;
   logic ch1_above_d;
   logic ch2_above_d;
   logic trig_true;
   logic ext_d;
   logic bus_d;

   // Comparators run every cycle regardless of state
   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_above_d <= 1'b0;
         ch2_above_d <= 1'b0;
         ext_d       <= 1'b0;
         bus_d       <= 1'b0;
      end else if (clk_en) begin
         ch1_above_d <= ch1_above;
         ch2_above_d <= ch2_above;
         ext_d       <= external_trigger_input;
         bus_d       <= intermodule_trigger_input;
      end
   end

   assign ch1_above = adc_ch1 >= cfg.trig_level;
   assign ch2_above = adc_ch2 >= cfg.trig_level;

   always_comb begin
      case (cfg.trig_source)
         `STC_SRC_CH1: trig_true = cfg.trig_slope_fall ? (ch1_above_d && !ch1_above)
                                                        : (!ch1_above_d && ch1_above);
         `STC_SRC_CH2: trig_true = cfg.trig_slope_fall ? (ch2_above_d && !ch2_above)
                                                        : (!ch2_above_d && ch2_above);
         // Bus trigger is edge-detected only, no level compare
         `STC_SRC_BUS: trig_true = intermodule_trigger_input && !bus_d;
         `STC_SRC_EXT: trig_true = external_trigger_input && !ext_d;
         default:      trig_true = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Acquisition sequencer
   // ----------------------------------------------------------------
   logic [`STC_CNT_BITS-1:0] seq_cnt;
   logic                     trig_event;

   assign trig_event = (state == ST_ARMED) && trig_true;

   always_ff @(posedge clk) begin
      if (rst) begin
         state        <= ST_IDLE;
         seq_cnt      <= '0;
         trigger_arm  <= 1'b0;
         acq_complete <= 1'b0;
      end else if (clk_en) begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state        <= ST_PRE;
                  seq_cnt      <= '0;
                  acq_complete <= 1'b0;
               end
            end
            ST_PRE: begin
               if (sample_tick) begin
                  if (seq_cnt + 1'b1 >= cfg.pre_count) begin
                     state       <= ST_ARMED;
                     trigger_arm <= 1'b1;
                  end
                  seq_cnt <= seq_cnt + 1'b1;
               end
            end
            ST_ARMED: begin
               if (trig_event) begin
                  state       <= ST_POST;
                  seq_cnt     <= cfg.post_count;
                  trigger_arm <= 1'b0;
               end
            end
            ST_POST: begin
               if (seq_cnt == '0) begin
                  state        <= ST_DONE;
                  acq_complete <= 1'b1;
               end else if (sample_tick) begin
                  seq_cnt <= seq_cnt - 1'b1;
               end
            end
            ST_DONE: begin
               if (start) begin
                  state        <= ST_PRE;
                  seq_cnt      <= '0;
                  acq_complete <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sample latch and ring memory
   // ----------------------------------------------------------------
   logic [SW-1:0] lat_ch1;
   logic [SW-1:0] lat_ch2;
   logic          lat_valid;
   logic [SW-1:0] ring_ch1 [RING_DEPTH];
   logic [SW-1:0] ring_ch2 [RING_DEPTH];

   always_ff @(posedge clk) begin
      if (rst) begin
         lat_ch1   <= '0;
         lat_ch2   <= '0;
         lat_valid <= 1'b0;
      end else if (clk_en) begin
         lat_valid <= sample_tick;
         if (sample_tick) begin
            lat_ch1 <= adc_ch1;
            lat_ch2 <= adc_ch2;
         end
      end
   end

   // Memory clock toggles per sample, so each edge stores one sample
   always_ff @(posedge clk) begin
      if (rst) begin
         ring_clock    <= 1'b0;
         ring_position <= '0;
      end else if (clk_en && lat_valid) begin
         ring_clock <= !ring_clock;
         // Position known only by counting clock edges
         if (ring_position == 13'(RING_DEPTH - 1))
            ring_position <= '0;
         else
            ring_position <= ring_position + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && lat_valid) begin
         ring_ch1[ring_position] <= lat_ch1;
         ring_ch2[ring_position] <= lat_ch2;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= '0;
      end else if (clk_en) begin
         rd_data.valid <= (state == ST_DONE) && (rd_index < 13'(RING_DEPTH));
         if (rd_index < 13'(RING_DEPTH)) begin
            rd_data.ch1 <= ring_ch1[rd_index];
            rd_data.ch2 <= ring_ch2[rd_index];
         end
      end
   end

   // ----------------------------------------------------------------
   // Trigger interval pulse and interpolation counter
   // ----------------------------------------------------------------
   logic interp_run;

   always_ff @(posedge clk) begin
      if (rst) begin
         interp_pulse <= 1'b0;
      end else if (clk_en) begin
         if (trig_event)
            interp_pulse <= 1'b1;
         else if (sample_tick)
            interp_pulse <= 1'b0;
      end
   end

   logic [`STC_INTERP_BITS-1:0] interp_acc;

   always_ff @(posedge clk) begin
      if (rst) begin
         interp_run   <= 1'b0;
         interp_acc   <= '0;
         interp_count <= '0;
      end else if (clk_en) begin
         if (trig_event) begin
            interp_run <= 1'b1;
            interp_acc <= '0;
         end else if (interp_run) begin
            if (interp_done) begin
               interp_run   <= 1'b0;
               interp_count <= interp_acc;
            end else begin
               interp_acc <= interp_acc + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Rear calibration output mux
   // ----------------------------------------------------------------
   logic [15:0] probe_cnt;
   logic        probe_wave;

   // Probe compensation square wave from the reference
   always_ff @(posedge clk) begin
      if (rst) begin
         probe_cnt  <= '0;
         probe_wave <= 1'b0;
      end else if (clk_en) begin
         if (probe_cnt == `STC_PROBE_HALF) begin
            probe_cnt  <= '0;
            probe_wave <= !probe_wave;
         end else begin
            probe_cnt <= probe_cnt + 1'b1;
         end
      end
   end

   // Reference is a clock, so 1 ns mode emits a toggle at clk/2 as its image
   always_ff @(posedge clk) begin
      if (rst) begin
         rear_calibration_mux <= 1'b0;
      end else if (clk_en) begin
         case (cfg.cal_mode)
            `STC_CAL_PROBE: rear_calibration_mux <= probe_wave;
            `STC_CAL_TRIG:  rear_calibration_mux <= trig_event;
            `STC_CAL_SELF:  rear_calibration_mux <= self_cal_signal;
            `STC_CAL_REF:   rear_calibration_mux <= cfg.period_1ns ? !rear_calibration_mux
                                                                   : 1'b0;
            default:        rear_calibration_mux <= 1'b0;
         endcase
      end
   end

endmodule

// File: stc_params.svh
// Constants for the scope time base, trigger and capture block.
// Assumes inclusion by the package, the design module and the checker file.
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

`define STC_RING_DEPTH     8000
`define STC_SAMPLE_BITS    8
`define STC_REF_FREQ_MHZ   100
`define STC_CLK_FREQ_MHZ   250
`define STC_DIV_BITS       16
`define STC_CNT_BITS       16
`define STC_INTERP_BITS    20
`define STC_SRC_CH1        2'h0
`define STC_SRC_CH2        2'h1
`define STC_SRC_BUS        2'h2
`define STC_SRC_EXT        2'h3
`define STC_CAL_PROBE      2'h0
`define STC_CAL_TRIG       2'h1
`define STC_CAL_SELF       2'h2
`define STC_CAL_REF        2'h3
`define STC_PROBE_HALF     16'h2710

`endif

// File: stc_pkg.sv
// Types shared by the scope time base, trigger and capture block.
// Assumes the parameter header is on the include path.
`include "stc_params.svh"

package stc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PRE,
      ST_ARMED,
      ST_POST,
      ST_DONE
   } stc_state_t;

   typedef struct packed {
      logic [1:0]                  trig_source;
      logic                        trig_slope_fall;
      logic [`STC_SAMPLE_BITS-1:0] trig_level;
      logic [`STC_DIV_BITS-1:0]    sample_div;
      logic [`STC_CNT_BITS-1:0]    pre_count;
      logic [`STC_CNT_BITS-1:0]    post_count;
      logic [1:0]                  cal_mode;
      logic                        period_1ns;
   } stc_cfg_t;

   typedef struct packed {
      logic                        valid;
      logic [`STC_SAMPLE_BITS-1:0] ch1;
      logic [`STC_SAMPLE_BITS-1:0] ch2;
   } stc_sample_t;

endpackage

// File: stc_acq_properties.sv
// Concurrent checks on the acquisition block's ports.
// Assumes it is bound onto every stc_acq instance.
`timescale 1ns/1ns
`include "stc_params.svh"
module stc_acq_props
   import stc_pkg::*;
#(
   parameter int RING_DEPTH = 8000
) (
   // Clock and control
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire stc_cfg_t    cfg,
   input wire logic        self_cal_signal,
   input wire logic [12:0] rd_index,
   // Outputs watched
   input wire stc_sample_t rd_data,
   input wire logic        trigger_arm,
   input wire logic        acq_complete,
   input wire logic        ring_clock,
   input wire logic        interp_pulse,
   input wire logic [12:0] ring_position,
   input wire logic        rear_calibration_mux
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence done_hold;
      acq_complete ##1 acq_complete;
   endsequence
   sequence self_mode;
      (clk_en && cfg.cal_mode == `STC_CAL_SELF)[*2];
   endsequence

   pos_range_a: assert property (ring_position < RING_DEPTH)
      else $error("ring position out of range");
   ring_step_a: assert property ($changed(ring_position) |-> ring_position ==
      (($past(ring_position) == RING_DEPTH - 1) ? 13'h0 : $past(ring_position) + 13'h1))
      else $error("ring position skipped");
   ring_halt_a: assert property (done_hold |-> $stable(ring_clock) && $stable(ring_position))
      else $error("ring clock runs after completion");
   arm_drop_a: assert property ($fell(trigger_arm) |-> interp_pulse && !acq_complete)
      else $error("arm dropped without trigger");
   pulse_cause_a: assert property ($rose(interp_pulse) |-> $past(trigger_arm))
      else $error("interpolator pulse while not armed");
   rd_valid_a: assert property (rd_data.valid && $past(clk_en) |->
      (acq_complete || $past(acq_complete)) && $past(rd_index) < RING_DEPTH)
      else $error("readback valid out of place");
   cal_self_a: assert property (self_mode |-> rear_calibration_mux == $past(self_cal_signal))
      else $error("cal output not following self cal");
   cal_ref_a: assert property ((clk_en && cfg.cal_mode == `STC_CAL_REF && cfg.period_1ns)[*3]
      |-> rear_calibration_mux != $past(rear_calibration_mux))
      else $error("cal output not toggling in reference mode");
   cal_off_a: assert property ((clk_en && cfg.cal_mode == `STC_CAL_REF && !cfg.period_1ns)[*2]
      |-> !rear_calibration_mux)
      else $error("reference on cal output without 1 ns period");
endmodule

bind stc_acq stc_acq_props #(.RING_DEPTH(RING_DEPTH)) u_props (
   .clk(clk), .rst(rst), .clk_en(clk_en), .cfg(cfg), .self_cal_signal(self_cal_signal),
   .rd_index(rd_index), .rd_data(rd_data), .trigger_arm(trigger_arm),
   .acq_complete(acq_complete), .ring_clock(ring_clock), .interp_pulse(interp_pulse),
   .ring_position(ring_position), .rear_calibration_mux(rear_calibration_mux));

// File: stc_interp_model.sv
// Behavioural interval stretcher facing the time base.
// Assumes the pulse arrives synchronous to clk.
`timescale 1ns/1ns
module stc_interp_model #(
   parameter int STRETCH = 8
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Stretcher handshake
   input  wire logic clk_en,
   input  wire logic interp_pulse,
   output logic      interp_done
);
   int remain;

   // Done stands one enabled cycle, so a stale level never ends the next count
   always_ff @(posedge clk) begin
      if (rst) begin
         remain      <= 0;
         interp_done <= 1'b0;
      end else if (clk_en) begin
         if (interp_pulse) begin
            remain      <= remain + STRETCH;
            interp_done <= 1'b0;
         end else if (remain == 1) begin
            remain      <= 0;
            interp_done <= 1'b1;
         end else begin
            interp_done <= 1'b0;
            if (remain != 0)
               remain <= remain - 1;
         end
      end
   end
endmodule

// File: scope_timebase_trigger_capture_tb_top.sv
// Self-checking bench for the acquisition block.
// Assumes the checker file is compiled alongside for its bind.
`timescale 1ns/1ns
module scope_timebase_trigger_capture_tb_top
   import stc_pkg::*;
;
   logic        clk, rst, clk_en, start, bus_trig, ext_trig, self_cal, interp_done;
   logic        trigger_arm, acq_complete, ring_clock, interp_pulse, rear_cal;
   logic        rnd_adc, rd_strobe, rd_seen, rc_prev, arm_prev;
   logic [7:0]  adc1, adc2, p;
   logic [12:0] rd_index, ring_position, idx;
   logic [19:0] interp_count;
   stc_cfg_t    cfg;
   stc_sample_t rd_data;
   int          fail_count, samples_checked, tog, pre;
   int          arm_q[$];
   stc_sample_t rd_q[$];

   stc_acq uut (.clk(clk), .rst(rst), .clk_en(clk_en), .start(start), .cfg(cfg),
      .adc_ch1(adc1), .adc_ch2(adc2), .intermodule_trigger_input(bus_trig),
      .external_trigger_input(ext_trig), .self_cal_signal(self_cal),
      .interp_done(interp_done), .rd_index(rd_index), .rd_data(rd_data),
      .trigger_arm(trigger_arm), .acq_complete(acq_complete), .ring_clock(ring_clock),
      .interp_pulse(interp_pulse), .interp_count(interp_count),
      .ring_position(ring_position), .rear_calibration_mux(rear_cal));
   stc_interp_model partner (.clk(clk), .rst(rst), .clk_en(clk_en), .interp_pulse(interp_pulse),
      .interp_done(interp_done));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Every input moves 1 ns after the edge; clk_en, self_cal and, with rnd_adc set, the ADC values move here
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         clk_en = ($urandom % 8) != 0;
         self_cal = $urandom;
         if (rnd_adc) begin
            adc1 = $urandom;
            adc2 = $urandom;
         end
      end
   endtask

   task automatic wait_for(input bit done);
      int n;
      n = 0;
      while ((done ? acq_complete : trigger_arm) !== 1'b1) begin
         step(1);
         n++;
         if (n > 2000) begin
            check(0, 1, "wait");
            finish_test();
         end
      end
   endtask

   // --------------------------------------------------------------
   // Monitor: results matched against the oldest note
   // --------------------------------------------------------------
   always @(posedge clk) begin
      #2;
      if (rd_seen) check(32'(rd_data), 32'(rd_q.pop_front()), "readback");
      rd_seen = rd_strobe;
      if (start) tog = 0;
      else if (ring_clock !== rc_prev) tog++;
      if (trigger_arm && !arm_prev && arm_q.size() > 0)
         check(tog, arm_q.pop_front(), "pre count");
      rc_prev = ring_clock;
      arm_prev = trigger_arm;
   end

   // --------------------------------------------------------------
   // Stimulus: one acquisition per trigger source and cal mode
   // --------------------------------------------------------------
   initial begin
      {rst, clk_en, start, bus_trig, ext_trig, self_cal, rnd_adc, rd_strobe} = 8'hc0;
      {rd_seen, rc_prev, arm_prev, adc1, adc2, rd_index, cfg} = '0;
      fail_count = 0;
      samples_checked = 0;
      tog = 0;
      void'($urandom(61));
      step(10);
      rst = 1'b0;
      for (int src = 0; src < 4; src++) begin
         cfg.trig_source = src[1:0];
         cfg.trig_slope_fall = src[0];
         cfg.trig_level = 8'h80;
         cfg.sample_div = 16'($urandom_range(1, 3));
         pre = $urandom_range(2, 5);
         cfg.pre_count = 16'(pre);
         cfg.post_count = 16'($urandom_range(2, 6));
         cfg.cal_mode = src[1:0];
         cfg.period_1ns = $urandom;
         p = src[0] ? 8'hff : 8'h00;
         // Last store before arm lands one enabled edge after arm rises
         arm_q.push_back(pre - 1);
         rnd_adc = 1'b1;
         start = 1'b1;
         clk_en = 1'b1;
         step(1);
         start = 1'b0;
         // Quiet channels before arm, so no stray crossing fires the trigger
         rnd_adc = 1'b0;
         adc1 = p;
         adc2 = p;
         // Early triggers must leave pre-trigger data whole
         {bus_trig, ext_trig} = 2'h3;
         step(2);
         {bus_trig, ext_trig} = 2'h0;
         wait_for(0);
         bus_trig = (src != 2);
         ext_trig = (src != 3);
         step(3);
         {bus_trig, ext_trig} = 2'h0;
         rnd_adc = 1'b0;
         adc1 = p;
         adc2 = p;
         step(20);
         check(32'(trigger_arm), 1, "armed");
         adc1 = ~p;
         adc2 = ~p;
         step(20);
         if (src > 1) begin
            check(32'(trigger_arm), 1, "armed");
            if (src == 2) bus_trig = 1'b1;
            else ext_trig = 1'b1;
            step(3);
            {bus_trig, ext_trig} = 2'h0;
         end
         wait_for(1);
         // Stretch may outlast the post count; let it finish
         step(100);
         check(32'(interp_count != 20'h0), 1, "interp count");
         idx = (ring_position == 13'h0) ? 13'd7999 : ring_position - 13'h1;
         rd_q.push_back({1'b1, ~p, ~p});
         rd_index = idx;
         rd_strobe = 1'b1;
         clk_en = 1'b1;
         step(1);
         rd_strobe = 1'b0;
         rd_index = 13'd8000;
         clk_en = 1'b1;
         step(4);
      end
      finish_test();
   end
endmodule
